// File: shared/pbc_regs.svh
// Register indices, bit positions and reset values of the
// bypass control and event counter register slice.
// Assumes word-aligned AHB-Lite access, byte address = index * 4.
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

`define PBC_IDX_BYPASS 8'h12
`define PBC_IDX_RXERR 8'h13
`define PBC_IDX_FCARR 8'h14
`define PBC_IDX_DROP 8'h15

`define PBC_BYPASS_RST 16'h0088
`define PBC_BYPASS_WMASK 16'hFEFE

`define PBC_B_TXOFF 15
`define PBC_B_STAGE_HI 14
`define PBC_B_STAGE_LO 10
`define PBC_B_LFI 9
`define PBC_B_MDIX_FORCED 7
`define PBC_B_NCDET 6
`define PBC_B_MDIX 5
`define PBC_B_POL 4
`define PBC_B_PDADV 3
`define PBC_B_PSF 2
`define PBC_B_NP 1

`define PBC_CNT_MAX 8'hFF
`define PBC_CNT_ZERO 8'h00
`define PBC_CNT_NUM 3
`define PBC_DATA_ZERO 32'h0000_0000

`endif

// File: shared/pbc_pkg.sv
// Types shared by the bypass control and event counter register slice.
// Assumes pbc_regs.svh supplies all numeric constants except the select codes defined below.
package pbc_pkg;
  typedef enum logic [2:0] {
    PBC_SEL_NONE = 3'h0,
    PBC_SEL_BYPASS = 3'h1,
    PBC_SEL_RXERR = 3'h2,
    PBC_SEL_FCARR = 3'h3,
    PBC_SEL_DROP = 3'h4
  } pbc_sel_t;
  typedef logic [7:0] pbc_cnt_t;
endpackage

// File: verilog/pbc_top.sv
// PHY bypass control register and three saturating clear-on-read counters.
// Assumes an AHB-Lite master with single word transfers, events synchronous to hclk.
//
// Behaviour
// R1 - Bypass bit 15, read/write and reset to zero, stops the transmitter driving the media.
// R2 - Bypass bits 14 to 10, reset to zero, bypass 4B/5B coding, scrambler, descrambler, PCS rx and PCS tx.
// R3 - Bypass bit 9 makes the link logic skip the link-fail inhibit timer and resets to zero.
// R4 - Bypass bit 7 resets to one and, while set, disables auto crossover when speed is forced to 10 or 100.
// R5 - Bypass bit 6 turns off detection of a non-compliant gigabit partner and resets to zero.
// R6 - Bypass bit 5 disables auto crossover correction and bit 4 disables polarity correction, both reset zero.
// R7 - Bypass bit 3 resets to one and makes parallel detection honour the advertised ability when set.
// R8 - Bypass bit 2 removes the 0.75/0.25 two-tap pulse-shaping filter from the gigabit transmitter.
// R9 - Bypass bit 1 stops automatic gigabit next-page exchanges and resets to zero.
// R10 - Index 19 bits 7:0 count 100 and 1000 receive errors, each only while its link is up.
// R11 - Index 20 bits 7:0 count 100 and 1000 false carriers, each only while its link is up.
// R12 - Index 21 bits 7:0 count every copper link drop at any speed.
// R13 - Each counter stops at 255 and never wraps.
// R14 - A read of a counter returns its value and then clears it; counters reset to zero.
// R15 - Reserved bits read zero and ignore writes, and counter writes change nothing.
// R16 - An event in the same cycle as a clearing read leaves the counter at one.
`timescale 1ns/1ps
`include "pbc_regs.svh"

module pbc_top (
  input wire logic hclk, // Bus clock, 25 MHz
  input wire logic hresetn, // Asynchronous reset
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic link_up_100, // 100BASE-TX link up
  input wire logic link_up_1000, // 1000BASE-T link up
  input wire logic forced_10_100, // Speed forced to 10 or 100
  input wire logic rx_err_100_evt, // 100 receive error pulse
  input wire logic rx_err_1000_evt, // 1000 receive error pulse
  input wire logic fcarr_100_evt, // 100 false carrier pulse
  input wire logic fcarr_1000_evt, // 1000 false carrier pulse
  input wire logic link_drop_evt, // Link drop pulse, any speed
  output logic tx_off, // Transmitter output disabled
  output logic [4:0] stage_bypass, // 4B5B, scr, descr, pcs rx, pcs tx
  output logic lfi_timer_bypass, // Skip link-fail inhibit timer
  output logic nc_detect_dis, // Non-compliant partner detect off
  output logic mdix_auto_en, // Auto crossover enabled
  output logic polarity_corr_dis, // Polarity correction off
  output logic pd_use_adv, // Parallel detect honours advertisement
  output logic pulse_shape_dis, // Gigabit pulse-shaping filter off
  output logic np_auto_dis // Automatic next-page exchange off
);
  import pbc_pkg::*;

  pbc_sel_t sel_r;
  logic rd_pend_r;
  logic wr_pend_r;
  logic ready_r;
  logic [31:0] rdata_r;
  logic [15:0] ctrl_r;
  logic mdix_r;
  pbc_cnt_t cnt_r [`PBC_CNT_NUM];
  logic [`PBC_CNT_NUM-1:0] ev_a;
  logic [`PBC_CNT_NUM-1:0] ev_b;
  logic [`PBC_CNT_NUM-1:0] clr;
  logic accept;
  logic [31:0] rd_val;
  logic hresp_r;

  function automatic pbc_sel_t pbc_decode(input logic [31:0] a);
    pbc_sel_t s;
    s = PBC_SEL_NONE;
    if (a[31:10] == 22'h000000) begin
      case (a[9:2])
        `PBC_IDX_BYPASS: s = PBC_SEL_BYPASS;
        `PBC_IDX_RXERR: s = PBC_SEL_RXERR;
        `PBC_IDX_FCARR: s = PBC_SEL_FCARR;
        `PBC_IDX_DROP: s = PBC_SEL_DROP;
        default: s = PBC_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // Clear first, then add, then saturate
  function automatic pbc_cnt_t pbc_cnt_next(input pbc_cnt_t c, input logic a, input logic b, input logic cl);
    logic [8:0] sum;
    sum = {1'b0, (cl ? `PBC_CNT_ZERO : c)} + {8'h00, a} + {8'h00, b};
    if (sum > {1'b0, `PBC_CNT_MAX}) begin
      return `PBC_CNT_MAX;
    end
    return sum[7:0];
  endfunction

  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_r <= PBC_SEL_NONE;
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end else begin
      if (hready) begin
        sel_r <= accept ? pbc_decode(haddr) : PBC_SEL_NONE;
      end
      rd_pend_r <= accept && !hwrite;
      wr_pend_r <= accept && hwrite;
    end
  end

  // One wait state on reads so that read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= !(accept && !hwrite);
    end
  end

  always_comb begin
    rd_val = `PBC_DATA_ZERO;
    case (sel_r)
      PBC_SEL_BYPASS: rd_val = {16'h0000, ctrl_r}; // R15
      PBC_SEL_RXERR: rd_val = {24'h000000, cnt_r[0]};
      PBC_SEL_FCARR: rd_val = {24'h000000, cnt_r[1]};
      PBC_SEL_DROP: rd_val = {24'h000000, cnt_r[2]};
      default: rd_val = `PBC_DATA_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= `PBC_DATA_ZERO;
    end else if (rd_pend_r) begin
      rdata_r <= rd_val; // R14
    end
  end

  // The slave never errors; the response still leaves from a flop like every other output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  // Only writable bits are stored; reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `PBC_BYPASS_RST; // R4 R7
    end else if (wr_pend_r && sel_r == PBC_SEL_BYPASS) begin
      ctrl_r <= hwdata[15:0] & `PBC_BYPASS_WMASK; // R1 R2 R3 R5 R6 R8 R9 R15
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mdix_r <= 1'b1;
    end else begin
      mdix_r <= !(ctrl_r[`PBC_B_MDIX] || (ctrl_r[`PBC_B_MDIX_FORCED] && forced_10_100)); // R4 R6
    end
  end

  assign ev_a = {link_drop_evt, fcarr_100_evt && link_up_100, rx_err_100_evt && link_up_100}; // R10 R11 R12
  assign ev_b = {1'b0, fcarr_1000_evt && link_up_1000, rx_err_1000_evt && link_up_1000}; // R10 R11
  assign clr = {rd_pend_r && sel_r == PBC_SEL_DROP,
                rd_pend_r && sel_r == PBC_SEL_FCARR,
                rd_pend_r && sel_r == PBC_SEL_RXERR}; // R14

  genvar g;
  generate
    for (g = 0; g < `PBC_CNT_NUM; g++) begin : g_cnt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_r[g] <= `PBC_CNT_ZERO; // R14
        end else begin
          cnt_r[g] <= pbc_cnt_next(cnt_r[g], ev_a[g], ev_b[g], clr[g]); // R13 R16
        end
      end
    end
  endgenerate

  assign hrdata = rdata_r;
  assign hreadyout = ready_r;
  assign hresp = hresp_r;
  assign tx_off = ctrl_r[`PBC_B_TXOFF];
  assign stage_bypass = ctrl_r[`PBC_B_STAGE_HI:`PBC_B_STAGE_LO];
  assign lfi_timer_bypass = ctrl_r[`PBC_B_LFI];
  assign nc_detect_dis = ctrl_r[`PBC_B_NCDET];
  assign mdix_auto_en = mdix_r;
  assign polarity_corr_dis = ctrl_r[`PBC_B_POL];
  assign pd_use_adv = ctrl_r[`PBC_B_PDADV];
  assign pulse_shape_dis = ctrl_r[`PBC_B_PSF];
  assign np_auto_dis = ctrl_r[`PBC_B_NP];

  logic bp_wr;
  assign bp_wr = wr_pend_r && sel_r == PBC_SEL_BYPASS;

  a_tx_off_write: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    bp_wr |=> tx_off == $past(hwdata[15]))
    else $error("tx_off does not follow bypass write");

  a_stage_bypass_write: assert property ( // R2
    @(posedge hclk) disable iff (!hresetn)
    bp_wr |=> stage_bypass == $past(hwdata[14:10]))
    else $error("stage bypass bits do not follow write");

  a_lfi_hold: assert property ( // R3
    @(posedge hclk) disable iff (!hresetn)
    !bp_wr |=> $stable(lfi_timer_bypass))
    else $error("link-fail timer bypass changed without write");

  a_mdix_forced_off: assert property ( // R4
    @(posedge hclk) disable iff (!hresetn)
    ctrl_r[`PBC_B_MDIX_FORCED] && forced_10_100 && !bp_wr |=> !mdix_auto_en)
    else $error("auto crossover on in forced 10/100");

  a_ncdet_write: assert property ( // R5
    @(posedge hclk) disable iff (!hresetn)
    bp_wr |=> nc_detect_dis == $past(hwdata[6]))
    else $error("non-compliant detect disable wrong");

  a_mdix_corr_off: assert property ( // R6
    @(posedge hclk) disable iff (!hresetn)
    bp_wr && hwdata[5] ##1 !bp_wr |=> !mdix_auto_en)
    else $error("crossover correction not disabled");

  a_pol_write: assert property ( // R6
    @(posedge hclk) disable iff (!hresetn)
    bp_wr |=> polarity_corr_dis == $past(hwdata[4]))
    else $error("polarity correction disable wrong");

  a_pdadv_write: assert property ( // R7
    @(posedge hclk) disable iff (!hresetn)
    bp_wr |=> pd_use_adv == $past(hwdata[3]))
    else $error("parallel detect advertisement bit wrong");

  a_psf_np_write: assert property ( // R8
    @(posedge hclk) disable iff (!hresetn)
    bp_wr |=> pulse_shape_dis == $past(hwdata[2]) && np_auto_dis == $past(hwdata[1])) // R9
    else $error("pulse shape or next-page bit wrong");

  a_rxerr_count: assert property ( // R10
    @(posedge hclk) disable iff (!hresetn)
    rx_err_100_evt && link_up_100 && !(rx_err_1000_evt && link_up_1000) && !clr[0] && cnt_r[0] < 8'hFE
    |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
    else $error("receive error counter missed an event");

  a_rxerr_linkdown: assert property ( // R10
    @(posedge hclk) disable iff (!hresetn)
    !link_up_100 && !link_up_1000 && !clr[0] |=> $stable(cnt_r[0]))
    else $error("receive error counted with link down");

  a_fcarr_both: assert property ( // R11
    @(posedge hclk) disable iff (!hresetn)
    fcarr_100_evt && link_up_100 && fcarr_1000_evt && link_up_1000 && !clr[1] && cnt_r[1] < 8'hF0
    |=> cnt_r[1] == $past(cnt_r[1]) + 8'h02)
    else $error("false carrier counter wrong");

  a_drop_count: assert property ( // R12
    @(posedge hclk) disable iff (!hresetn)
    link_drop_evt && !clr[2] && cnt_r[2] < 8'hFE ##1 !link_drop_evt && !clr[2]
    |=> cnt_r[2] == $past(cnt_r[2], 2) + 8'h01)
    else $error("link drop counter wrong");

  a_cnt_saturate: assert property ( // R13
    @(posedge hclk) disable iff (!hresetn)
    cnt_r[2] == 8'hFF && !clr[2] |=> cnt_r[2] == 8'hFF)
    else $error("link drop counter wrapped");

  a_read_clear: assert property ( // R14
    @(posedge hclk) disable iff (!hresetn)
    clr[0] && !ev_a[0] && !ev_b[0]
    |=> cnt_r[0] == 8'h00 && hrdata[7:0] == $past(cnt_r[0]) && hreadyout)
    else $error("counter read did not return and clear");

  a_rsvd_zero: assert property ( // R15
    @(posedge hclk) disable iff (!hresetn)
    $rose(hreadyout) |-> hrdata[31:16] == 16'h0000
      && (sel_r != PBC_SEL_BYPASS || (hrdata[8] == 1'b0 && hrdata[0] == 1'b0))
      && (sel_r == PBC_SEL_BYPASS || hrdata[15:8] == 8'h00))
    else $error("reserved bits read nonzero");

  a_clear_event: assert property ( // R16
    @(posedge hclk) disable iff (!hresetn)
    clr[2] && link_drop_evt |=> cnt_r[2] == 8'h01)
    else $error("event lost on clearing read");

  a_clear_fcarr: assert property ( // R16
    @(posedge hclk) disable iff (!hresetn)
    clr[1] && fcarr_1000_evt && link_up_1000 && !(fcarr_100_evt && link_up_100)
    |=> cnt_r[1] == 8'h01)
    else $error("false carrier event lost on clearing read");

  a_fcarr_linkdown: assert property ( // R11
    @(posedge hclk) disable iff (!hresetn)
    !link_up_100 && !link_up_1000 && !clr[1] |=> $stable(cnt_r[1]))
    else $error("false carrier counted with link down");

  a_rxerr_both: assert property ( // R10
    @(posedge hclk) disable iff (!hresetn)
    rx_err_100_evt && link_up_100 && rx_err_1000_evt && link_up_1000 && !clr[0] && cnt_r[0] < 8'hF0
    |=> cnt_r[0] == $past(cnt_r[0]) + 8'h02)
    else $error("receive error counter missed a dual event");

  a_read_wait: assert property ( // R14
    @(posedge hclk) disable iff (!hresetn)
    rd_pend_r |-> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");

  a_rsvd_write: assert property ( // R15
    @(posedge hclk) disable iff (!hresetn)
    bp_wr |=> ctrl_r[8] == 1'b0 && ctrl_r[0] == 1'b0 && ctrl_r[15:9] == $past(hwdata[15:9]))
    else $error("bypass write stored reserved bits");

  a_cnt_write_ignored: assert property ( // R15
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_r && sel_r == PBC_SEL_RXERR && !(rx_err_100_evt && link_up_100)
    && !(rx_err_1000_evt && link_up_1000) |=> $stable(cnt_r[0]))
    else $error("counter changed by a write");

  a_mdix_reenable: assert property ( // R4
    @(posedge hclk) disable iff (!hresetn)
    !ctrl_r[`PBC_B_MDIX] && !(ctrl_r[`PBC_B_MDIX_FORCED] && forced_10_100) |=> mdix_auto_en)
    else $error("auto crossover off without cause");

  a_rdata_hold: assert property ( // R14
    @(posedge hclk) disable iff (!hresetn)
    !rd_pend_r |=> $stable(hrdata))
    else $error("read data changed outside a read");

  a_drop_clear: assert property ( // R14
    @(posedge hclk) disable iff (!hresetn)
    clr[2] && !link_drop_evt
    |=> cnt_r[2] == 8'h00 && hrdata[7:0] == $past(cnt_r[2]))
    else $error("link drop read did not return and clear");

  a_fcarr_clear: assert property ( // R14
    @(posedge hclk) disable iff (!hresetn)
    clr[1] && !ev_a[1] && !ev_b[1]
    |=> cnt_r[1] == 8'h00 && hrdata[7:0] == $past(cnt_r[1]))
    else $error("false carrier read did not return and clear");

endmodule

// File: verif/pbc_host.sv
// Management host model: single-word AHB-Lite master for the register slice.
// Assumes hready is the slave's hreadyout; a wait that runs out raises tmo.
`timescale 1ns/1ps

module pbc_host (
  input wire logic hclk, // Bus clock
  input wire logic hreadyout, // Slave ready, also the bus hready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Slave select
  output logic [31:0] haddr, // Byte address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write when high
  output logic [2:0] hsize, // Always word
  output logic [31:0] hwdata, // Write data
  output logic tmo // A wait ran out
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tmo = 1'b0;
  end

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) tmo = 1'b1;
  endtask

  // Released address and data lines carry the inverse of their last value; hsel and htrans return to zero
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the bypass control register and event counters.
// Assumes the host model drives the bus and the bench drives the event lines.
`timescale 1ns/1ps

module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tmo;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic lu100, lu1000, forced, rx100, rx1000, fc100, fc1000, drop;
  logic tx_off, lfi, ncd, mdix, pol, pda, psd, npd;
  logic [4:0] stg;
  int miscompares = 0;
  int checked = 0;
  // Each row: write data in the upper half, expected readback in the lower
  localparam logic [31:0] rows [6] = '{32'hFFFF_FEFE, 32'h0000_0000, 32'h8000_8000,
                                       32'h5555_5454, 32'hAAAA_AAAA, 32'h0101_0000};

  pbc_host host_u (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .tmo(tmo));

  pbc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_up_100(lu100), .link_up_1000(lu1000),
    .forced_10_100(forced), .rx_err_100_evt(rx100), .rx_err_1000_evt(rx1000), .fcarr_100_evt(fc100),
    .fcarr_1000_evt(fc1000), .link_drop_evt(drop), .tx_off(tx_off), .stage_bypass(stg),
    .lfi_timer_bypass(lfi), .nc_detect_dis(ncd), .mdix_auto_en(mdix), .polarity_corr_dis(pol),
    .pd_use_adv(pda), .pulse_shape_dis(psd), .np_auto_dis(npd));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic report_and_stop();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
    if (tmo) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0, q);
    if (tmo) begin
      miscompares++;
      report_and_stop();
    end
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  initial begin
    hresetn = 1'b0;
    {lu100, lu1000, forced, rx100, rx1000, fc100, fc1000, drop} = 8'h00;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h48, 32'h88);
    chk({30'h0, pda, mdix}, 32'h3);
    rd(32'h4C, 32'h0);
    rd(32'h50, 32'h0);
    rd(32'h54, 32'h0);
    foreach (rows[i]) begin
      wr(32'h48, {16'h0, rows[i][31:16]});
      rd(32'h48, {16'h0, rows[i][15:0]});
      @(posedge hclk);
      chk({16'h0, tx_off, stg, lfi, 2'b0, ncd, 1'b0, pol, pda, psd, npd, 1'b0}, {16'h0, rows[i][15:0] & 16'hFE5E});
      chk({31'h0, mdix}, {31'h0, ~rows[i][5]});
    end
    wr(32'h48, 32'h88);
    forced <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({31'h0, mdix}, 32'h0);
    wr(32'h48, 32'h08);
    repeat (2) @(posedge hclk);
    chk({31'h0, mdix}, 32'h1);
    forced <= 1'b0;
    wr(32'h4C, 32'hFF);
    rd(32'h4C, 32'h0);
    rd(32'h58, 32'h0);
    lu100 <= 1'b1;
    repeat (3) @(posedge hclk) rx100 <= 1'b1;
    @(posedge hclk) rx100 <= 1'b0;
    repeat (2) @(posedge hclk) rx1000 <= 1'b1;
    @(posedge hclk) lu1000 <= 1'b1;
    @(posedge hclk) rx100 <= 1'b1;
    @(posedge hclk) {rx100, rx1000} <= 2'b00;
    rd(32'h4C, 32'h6);
    rd(32'h4C, 32'h0);
    @(posedge hclk) {fc100, fc1000} <= 2'b11;
    @(posedge hclk) {fc100, fc1000} <= 2'b00;
    rd(32'h50, 32'h2);
    lu100 <= 1'b0;
    repeat (2) @(posedge hclk) fc100 <= 1'b1;
    @(posedge hclk) fc100 <= 1'b0;
    repeat (4) @(posedge hclk) fc1000 <= 1'b1;
    @(posedge hclk) fc1000 <= 1'b0;
    rd(32'h50, 32'h4);
    repeat (300) @(posedge hclk) drop <= 1'b1;
    @(posedge hclk) drop <= 1'b0;
    rd(32'h54, 32'hFF);
    rd(32'h54, 32'h0);
    @(posedge hclk) drop <= 1'b1;
    @(posedge hclk) drop <= 1'b0;
    rd(32'h54, 32'h1);
    @(posedge hclk) fc1000 <= 1'b1;
    rd(32'h50, 32'h2);
    fc1000 <= 1'b0;
    rd(32'h50, 32'h2);
    @(posedge hclk) drop <= 1'b1;
    rd(32'h54, 32'h2);
    drop <= 1'b0;
    rd(32'h54, 32'h2);
    // Reset in mid-run must return the bypass defaults and an empty link drop counter
    @(posedge hclk) drop <= 1'b1;
    @(posedge hclk) {drop, hresetn} <= 2'b00;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h54, 32'h0);
    rd(32'h48, 32'h88);
    report_and_stop();
  end
endmodule
